// File: rtl/tccg_pkg.sv
// Types for the capture/compare/gated timer block
package tccg_pkg;
    typedef enum logic [2:0] {
        TCCG_OFF, TCCG_CAPTURE, TCCG_CAP_RESTART, TCCG_COMPARE, TCCG_GATED, TCCG_CAPCMP
    } tccg_mode_t;
endpackage

// File: rtl/tccg_regs.svh
// Constants for the capture/compare/gated timer block
`ifndef TCCG_REGS_SVH
`define TCCG_REGS_SVH
`define TCCG_RESTART_COUNT 16'h0001
`define TCCG_ZERO_COUNT 16'h0000
`define TCCG_MODE_ONE_SHOT 4'h0
`define TCCG_MODE_CAPTURE 4'h4
`define TCCG_MODE_COMPARE 4'h5
`define TCCG_MODE_GATED 4'h6
`define TCCG_MODE_CAPCMP 4'h7
`define TCCG_MODE_CAP_RESTART 4'hA
`define TCCG_IRQ_INPUT_ONLY 2'h2
`define TCCG_IRQ_RELOAD_ONLY 2'h3
`define TCCG_PRES_RESET 3'h0
`endif

// File: rtl/tccg_timer.sv
// Timer core with capture, capture restart, compare, gated and capture/compare modes
`timescale 1ns/1ps
`include "tccg_regs.svh"
module tccg_timer (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic enable_in,
    input wire logic [3:0] mode_select_field_in,
    input wire logic mode_select_top_bit_in,
    input wire logic edge_level_polarity_in,
    input wire logic [1:0] irq_source_select_in,
    input wire logic [2:0] prescale_in,
    input wire logic [15:0] reload_value_in,
    input wire logic count_load_in,
    input wire logic [15:0] count_load_value_in,
    input wire logic capture_clear_in,
    input wire logic output_enable_in,
    input wire logic timer_input_in,
    output logic [15:0] count_out,
    output logic [15:0] capture_value_out,
    output logic capture_cause_flag_out,
    output logic irq_out,
    output logic timer_output_out
);
    import tccg_pkg::*;

    logic in_sync1_reg, in_sync2_reg, in_prev_reg;
    logic [6:0] pres_reg;
    logic [15:0] count_reg;
    logic [15:0] capture_reg;
    logic flag_reg;
    logic irq_reg;
    logic out_reg;
    logic started_reg;
    logic tick, rise, fall, sel_edge, active, leave_active;
    logic reached, input_evt, reload_evt, input_irq, reload_irq;
    logic [6:0] pres_next;
    logic [15:0] count_next;
    logic [15:0] capture_next;
    logic flag_next, irq_next, out_next, started_next, capture_evt;
    tccg_mode_t mode;

    // Wraps through FFFFH to 0000H by itself, which compare mode relies on
    function automatic logic [15:0] count_step(input logic [15:0] c);
        count_step = c + 16'h0001;
    endfunction

    function automatic logic irq_allowed(input logic [1:0] sel, input logic is_input);
        if (!sel[1]) begin
            irq_allowed = 1'b1;
        end else if (sel == `TCCG_IRQ_INPUT_ONLY) begin
            irq_allowed = is_input;
        end else begin
            irq_allowed = !is_input;
        end
    endfunction

    // Mode from top bit and field; settings are assumed stable while enabled
    always_comb begin
        unique case ({mode_select_top_bit_in, mode_select_field_in[2:0]})
            `TCCG_MODE_CAPTURE: mode = TCCG_CAPTURE;
            `TCCG_MODE_COMPARE: mode = TCCG_COMPARE;
            `TCCG_MODE_GATED: mode = TCCG_GATED;
            `TCCG_MODE_CAPCMP: mode = TCCG_CAPCMP;
            `TCCG_MODE_CAP_RESTART: mode = TCCG_CAP_RESTART;
            default: mode = TCCG_OFF;
        endcase
    end

    // Two flops before any edge logic looks at the pin
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            in_sync1_reg <= 1'b0;
            in_sync2_reg <= 1'b0;
            in_prev_reg <= 1'b0;
        end else begin
            in_sync1_reg <= timer_input_in;
            in_sync2_reg <= in_sync1_reg;
            in_prev_reg <= in_sync2_reg;
        end
    end

    assign rise = in_sync2_reg && !in_prev_reg;
    assign fall = !in_sync2_reg && in_prev_reg;
    assign sel_edge = edge_level_polarity_in ? fall : rise;
    assign active = edge_level_polarity_in ? !in_sync2_reg : in_sync2_reg;
    assign leave_active = edge_level_polarity_in ? rise : fall;

    // Prescaler divides by 2 to the power of prescale_in
    always_comb begin
        pres_next = pres_reg + 7'h01;
        if (!enable_in) begin
            pres_next = 7'h00;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pres_reg <= 7'h00;
        end else begin
            pres_reg <= pres_next;
        end
    end
    assign tick = enable_in && ((pres_reg & 7'((8'h01 << prescale_in) - 8'h01)) == 7'h00);

    assign reached = tick && (count_reg == reload_value_in);
    always_comb begin
        input_evt = 1'b0;
        reload_evt = 1'b0;
        if (enable_in) begin
            unique case (mode)
                TCCG_CAPTURE, TCCG_CAP_RESTART: begin
                    input_evt = sel_edge;
                    reload_evt = reached && !sel_edge;
                end
                TCCG_COMPARE: reload_evt = reached;
                TCCG_GATED: begin
                    input_evt = leave_active;
                    reload_evt = reached && active;
                end
                TCCG_CAPCMP: begin
                    input_evt = sel_edge && started_reg;
                    reload_evt = reached && started_reg && !sel_edge;
                end
                TCCG_OFF: ;
            endcase
        end
    end
    assign input_irq = input_evt;
    assign reload_irq = reload_evt;

    // Capture/compare run flag: first edge only starts the count
    always_comb begin
        started_next = started_reg;
        if (!enable_in || mode != TCCG_CAPCMP) begin
            started_next = 1'b0;
        end else if (sel_edge) begin
            started_next = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= started_next;
        end
    end

    // Counter; restart value after each reset in capture restart, gated and capture/compare modes, so a loaded start count covers one pass
    always_comb begin
        count_next = count_reg;
        if (!enable_in) begin
            if (count_load_in) begin
                count_next = count_load_value_in;
            end
        end else begin
            unique case (mode)
                TCCG_CAPTURE: begin
                    if (tick) begin
                        count_next = count_step(count_reg);
                    end
                end
                TCCG_CAP_RESTART: begin
                    if (sel_edge || reached) begin
                        count_next = `TCCG_RESTART_COUNT;
                    end else if (tick) begin
                        count_next = count_step(count_reg);
                    end
                end
                TCCG_COMPARE: begin
                    if (tick) begin
                        count_next = count_step(count_reg);
                    end
                end
                TCCG_GATED: begin
                    if (tick && active) begin
                        count_next = reached ? `TCCG_RESTART_COUNT : count_step(count_reg);
                    end
                end
                TCCG_CAPCMP: begin
                    if (started_reg && (sel_edge || reached)) begin
                        count_next = `TCCG_RESTART_COUNT;
                    end else if (started_reg && tick) begin
                        count_next = count_step(count_reg);
                    end
                end
                TCCG_OFF: begin
                    count_next = count_reg;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count_reg <= `TCCG_ZERO_COUNT;
        end else begin
            count_reg <= count_next;
        end
    end

    // Gated deassertion interrupts but records nothing
    assign capture_evt = input_evt && (mode != TCCG_GATED);

    // Capture register; software zeroes it to tell reloads from captures, a capture beats a clear
    always_comb begin
        capture_next = capture_reg;
        if (capture_evt) begin
            capture_next = count_reg;
        end else if (capture_clear_in) begin
            capture_next = `TCCG_ZERO_COUNT;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            capture_reg <= `TCCG_ZERO_COUNT;
        end else begin
            capture_reg <= capture_next;
        end
    end

    // Cause flag tracks the latest capture or reload, whether or not its interrupt is enabled
    always_comb begin
        flag_next = flag_reg;
        if (capture_evt) begin
            flag_next = 1'b1;
        end else if (reload_evt) begin
            flag_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign irq_next = (input_irq && irq_allowed(irq_source_select_in, 1'b1)) ||
        (reload_irq && irq_allowed(irq_source_select_in, 1'b0));

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // Output idles at polarity level while disabled
    always_comb begin
        out_next = out_reg;
        if (!enable_in) begin
            out_next = edge_level_polarity_in;
        end else if (output_enable_in && reload_evt && (mode == TCCG_COMPARE || mode == TCCG_GATED)) begin
            out_next = !out_reg;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
        end
    end

    assign count_out = count_reg;
    assign capture_value_out = capture_reg;
    assign capture_cause_flag_out = flag_reg;
    assign irq_out = irq_reg;
    assign timer_output_out = out_reg;
endmodule

// File: verification/tccg_pin_model.sv
// Model of the external signal on the timer input pin
`timescale 1ns/1ps
module tccg_pin_model (
    input wire logic mclk_in,
    output logic pin_out
);
    initial pin_out = 1'b0;
    // Changes just after an edge; callers hold each level several clocks for the synchroniser
    task automatic drive(input logic lvl);
        @(posedge mclk_in);
        #2 pin_out = lvl;
    endtask
endmodule

// File: verification/tccg_timer_monitor.sv
// Assertion checker for the capture/compare/gated timer
`timescale 1ns/1ps
`include "tccg_regs.svh"
module tccg_timer_monitor (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic enable_in,
    input wire logic [3:0] mode_select_field_in,
    input wire logic mode_select_top_bit_in,
    input wire logic edge_level_polarity_in,
    input wire logic [1:0] irq_source_select_in,
    input wire logic [2:0] prescale_in,
    input wire logic [15:0] reload_value_in,
    input wire logic output_enable_in,
    input wire logic timer_input_in,
    input wire logic [15:0] count_out,
    input wire logic [15:0] capture_value_out,
    input wire logic capture_cause_flag_out,
    input wire logic irq_out,
    input wire logic timer_output_out
);
    logic [3:0] md;
    logic cap_md;
    assign md = {mode_select_top_bit_in, mode_select_field_in[2:0]};
    assign cap_md = enable_in && (md == `TCCG_MODE_CAPTURE || md == `TCCG_MODE_CAP_RESTART);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    // Five idle cycles cover the synchroniser delay before the gate closes
    sequence s_gate_idle;
        enable_in && md == `TCCG_MODE_GATED && timer_input_in == edge_level_polarity_in;
    endsequence
    sequence s_cmp_run;
        enable_in && md == `TCCG_MODE_COMPARE && prescale_in == 3'h0;
    endsequence
    property p_cap_value;
        cap_md && irq_out && capture_cause_flag_out |-> capture_value_out == $past(count_out);
    endproperty
    a_cap_value: assert property (p_cap_value) else $error("capture value differs from count");
    property p_restart;
        enable_in && (md == `TCCG_MODE_CAP_RESTART || md == `TCCG_MODE_CAPCMP) && irq_out
            |-> count_out == `TCCG_RESTART_COUNT;
    endproperty
    a_restart: assert property (p_restart) else $error("count not restarted");
    property p_cmp_irq;
        enable_in && md == `TCCG_MODE_COMPARE && irq_out |-> $past(count_out) == reload_value_in;
    endproperty
    a_cmp_irq: assert property (p_cmp_irq) else $error("compare irq off match");
    property p_cmp_toggle;
        enable_in && $past(enable_in) && md == `TCCG_MODE_COMPARE && output_enable_in && irq_out
            |-> timer_output_out != $past(timer_output_out);
    endproperty
    a_cmp_toggle: assert property (p_cmp_toggle) else $error("output not toggled");
    property p_cmp_step;
        s_cmp_run [*2] |=> count_out == $past(count_out) + 16'h0001;
    endproperty
    a_cmp_step: assert property (p_cmp_step) else $error("compare count step wrong");
    property p_gate_hold;
        s_gate_idle [*5] |=> $stable(count_out);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("count moved while gated off");
    property p_input_only;
        cap_md && irq_source_select_in == `TCCG_IRQ_INPUT_ONLY && irq_out |-> capture_cause_flag_out;
    endproperty
    a_input_only: assert property (p_input_only) else $error("reload irq not masked");
    property p_reload_only;
        cap_md && irq_source_select_in == `TCCG_IRQ_RELOAD_ONLY && irq_out |-> !capture_cause_flag_out;
    endproperty
    a_reload_only: assert property (p_reload_only) else $error("capture irq not masked");
endmodule
bind tccg_timer tccg_timer_monitor i_monitor (.mclk_in(mclk_in), .nrst_in(nrst_in), .enable_in(enable_in),
    .mode_select_field_in(mode_select_field_in), .mode_select_top_bit_in(mode_select_top_bit_in),
    .edge_level_polarity_in(edge_level_polarity_in), .irq_source_select_in(irq_source_select_in),
    .prescale_in(prescale_in), .reload_value_in(reload_value_in), .output_enable_in(output_enable_in),
    .timer_input_in(timer_input_in), .count_out(count_out), .capture_value_out(capture_value_out),
    .capture_cause_flag_out(capture_cause_flag_out), .irq_out(irq_out), .timer_output_out(timer_output_out));

// File: verification/tccg_timer_test.sv
// Self-checking testbench for the capture/compare/gated timer
`timescale 1ns/1ps
`include "tccg_regs.svh"
module tccg_timer_test;
    import tccg_pkg::*;
    logic mclk_in = 1'b0, nrst_in = 1'b0, enable_in = 1'b0, top_bit = 1'b0, pol = 1'b0;
    logic count_load_in = 1'b0, capture_clear_in = 1'b0, output_enable_in = 1'b1, timer_input_in;
    logic [3:0] field = 4'h0;
    logic [1:0] sel = 2'h0;
    logic [2:0] prescale_in = 3'h0;
    logic [15:0] reload = 16'h0000, start = 16'h0000, count_out, capture_value_out;
    logic capture_cause_flag_out, irq_out, timer_output_out;
    int err_total = 0;
    int n_checks = 0;
    always #12.5 mclk_in = ~mclk_in;
    tccg_timer i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .enable_in(enable_in), .mode_select_field_in(field),
        .mode_select_top_bit_in(top_bit), .edge_level_polarity_in(pol), .irq_source_select_in(sel),
        .prescale_in(prescale_in), .reload_value_in(reload), .count_load_in(count_load_in),
        .count_load_value_in(start), .capture_clear_in(capture_clear_in), .output_enable_in(output_enable_in),
        .timer_input_in(timer_input_in), .count_out(count_out), .capture_value_out(capture_value_out),
        .capture_cause_flag_out(capture_cause_flag_out), .irq_out(irq_out), .timer_output_out(timer_output_out));
    tccg_pin_model i_pin (.mclk_in(mclk_in), .pin_out(timer_input_in));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Stop, load mode, start count and cleared capture, then enable; loads are refused while running
    task automatic setup(input logic [3:0] md, input logic p, input logic [1:0] s, input logic [15:0] st,
        input logic [15:0] rl);
        @(posedge mclk_in);
        #2 enable_in = 1'b0;
        {top_bit, field} = {md[3], 1'b0, md[2:0]};
        {pol, sel, start, reload} = {p, s, st, rl};
        count_load_in = 1'b1;
        capture_clear_in = 1'b1;
        @(posedge mclk_in);
        #2 {count_load_in, capture_clear_in, enable_in} = 3'b001;
    endtask
    // Bounded wait; a missing wanted irq ends the run
    task automatic wait_irq(input int lim, input logic want);
        int i;
        @(posedge mclk_in);
        #1;
        for (i = 0; i < lim && irq_out !== 1'b1; i++) begin
            @(posedge mclk_in);
            #1;
        end
        check({15'h0, irq_out}, {15'h0, want});
        if (want && irq_out !== 1'b1) stop_test();
    endtask
    initial begin
        repeat (8) @(posedge mclk_in);
        #2 nrst_in = 1'b1;
        check(count_out, 16'h0000);
        setup(`TCCG_MODE_CAPTURE, 1'b0, 2'h0, 16'h0001, 16'h0040);
        i_pin.drive(1'b1);
        wait_irq(20, 1'b1);
        check({15'h0, capture_cause_flag_out}, 16'h0001);
        check(capture_value_out, 16'h0004);
        wait_irq(80, 1'b1);
        check({15'h0, capture_cause_flag_out}, 16'h0000);
        check(count_out, 16'h0041);
        setup(`TCCG_MODE_CAP_RESTART, 1'b1, `TCCG_IRQ_INPUT_ONLY, 16'h0001, 16'h0030);
        i_pin.drive(1'b0);
        wait_irq(20, 1'b1);
        check({15'h0, capture_cause_flag_out}, 16'h0001);
        check(count_out, `TCCG_RESTART_COUNT);
        wait_irq(60, 1'b0);
        setup(`TCCG_MODE_CAP_RESTART, 1'b0, `TCCG_IRQ_RELOAD_ONLY, 16'h0001, 16'h0030);
        i_pin.drive(1'b1);
        wait_irq(70, 1'b1);
        check({15'h0, capture_cause_flag_out}, 16'h0000);
        check(count_out, `TCCG_RESTART_COUNT);
        setup(`TCCG_MODE_COMPARE, 1'b0, 2'h0, 16'hFFF0, 16'hFFF8);
        wait_irq(30, 1'b1);
        check(count_out, 16'hFFF9);
        check({15'h0, timer_output_out}, 16'h0001);
        repeat (8) @(posedge mclk_in);
        #1;
        check(count_out, 16'h0001);
        i_pin.drive(1'b0);
        setup(`TCCG_MODE_GATED, 1'b0, 2'h0, 16'h0010, 16'h0018);
        repeat (10) @(posedge mclk_in);
        #1;
        check(count_out, 16'h0010);
        i_pin.drive(1'b1);
        wait_irq(30, 1'b1);
        check(count_out, `TCCG_RESTART_COUNT);
        check({15'h0, timer_output_out}, 16'h0001);
        i_pin.drive(1'b0);
        wait_irq(10, 1'b1);
        setup(`TCCG_MODE_CAPCMP, 1'b0, 2'h0, 16'h0005, 16'h0100);
        repeat (10) @(posedge mclk_in);
        #1;
        check(count_out, 16'h0005);
        i_pin.drive(1'b1);
        wait_irq(10, 1'b0);
        check({15'h0, count_out !== 16'h0005}, 16'h0001);
        i_pin.drive(1'b0);
        repeat (3) @(posedge mclk_in);
        i_pin.drive(1'b1);
        wait_irq(10, 1'b1);
        check({15'h0, capture_cause_flag_out}, 16'h0001);
        check(count_out, `TCCG_RESTART_COUNT);
        @(posedge mclk_in);
        #2 {prescale_in, output_enable_in} = {3'h1, 1'b0};
        setup(`TCCG_MODE_COMPARE, 1'b0, 2'h0, 16'h0002, 16'h0004);
        wait_irq(20, 1'b1);
        check(count_out, 16'h0005);
        check({15'h0, timer_output_out}, 16'h0000);
        @(posedge mclk_in);
        #1;
        check(count_out, 16'h0005);
        stop_test();
    end
endmodule
